// file: include/cid_pkg.sv
// Shared constants of the interrupt dispatch block.
package cid_pkg;
    // Number of interrupt sources and the width of a source index.
    localparam int          NUM_SRC     = 13;
    localparam int          SRC_W       = 4;
    // Register bus geometry.
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    // Register byte offsets.
    localparam logic [7:0]  OFS_PEND    = 8'h00;
    localparam logic [7:0]  OFS_PCLR    = 8'h04;
    localparam logic [7:0]  OFS_ENP     = 8'h08;
    localparam logic [7:0]  OFS_ENX     = 8'h0C;
    localparam logic [7:0]  OFS_PRIO    = 8'h10;
    localparam logic [7:0]  OFS_STAT    = 8'h14;
    localparam logic [7:0]  OFS_MASK    = 8'h18;
    localparam logic [7:0]  OFS_STATE   = 8'h1C;
    // Field positions of the enable registers.
    localparam int          GLOB_BIT    = 7;
    localparam int          ENP_SRC_W   = 7;
    localparam int          ENX_SRC_W   = 6;
    // Field positions of the status and state registers.
    localparam int          EV_DISP     = 0;
    localparam int          EV_PREEMPT  = 1;
    localparam int          EV_RETURN_FROM_SERVICE     = 2;
    localparam int          EV_W        = 3;
    localparam int          ST_ACT_LO   = 0;
    localparam int          ST_ACT_HI   = 1;
    localparam int          ST_BUSY     = 2;
    localparam int          ST_SKIP     = 3;
    localparam int          ST_SRC_LSB  = 4;
    // Reset values.
    localparam logic [7:0]  RST_EN      = 8'h00;
    localparam logic [15:0] RST_SRCS    = 16'h0000;
    localparam logic [2:0]  RST_EV      = 3'h0;
    // Timing counts in system clock cycles.
    localparam int          DETECT_CYC  = 1;
    localparam logic [2:0]  LONG_SUBROUTINE_CALL_CYC   = 3'h4;
    // Fixed vector map: base address and step as a shift.
    localparam logic [15:0] VEC_BASE    = 16'h0003;
    localparam int          VEC_SHIFT   = 3;
endpackage

// file: include/cid_regbus_if.sv
// Internal register strobe bus between the bus slave and the register file.
interface cid_regbus_if;
    logic        wr;     // One-cycle write strobe for a mapped address.
    logic [7:0]  addr;   // Byte address of the access.
    logic [31:0] wdata;  // Write data.
    logic [31:0] rdata;  // Read data of the addressed register.
    logic        hit;    // Address is mapped.
    modport slave (output wr, output addr, output wdata, input rdata, input hit);
    modport regs  (input wr, input addr, input wdata, output rdata, output hit);
endinterface

// file: design/cid_prio_pick.sv
// Fixed-order picker: returns the lowest set index of a request vector.
module cid_prio_pick #(
    parameter int N = 13,
    parameter int W = 4
) (
    // Request vector.
    input  wire logic [N-1:0] req_in,
    // Result.
    output logic              any_out,
    output logic [W-1:0]      idx_out
);
    // The index must be wide enough for every source.
    if (N > (1 << W))
    begin : g_chk
        $error("Picker index too narrow.");
    end

    // Scan from the top down so the lowest index wins the tie.
    always_comb
    begin
        any_out = 1'b0;
        idx_out = '0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req_in[i])
            begin
                any_out = 1'b1;
                idx_out = W'(i);
            end
        end
    end
endmodule

// file: design/cid_apb_slave.sv
// APB slave front end with zero wait states and error on unmapped addresses.
module cid_apb_slave import cid_pkg::*; (
    // Clock and reset.
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // APB requester side.
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [DATA_W-1:0] pwdata_in,
    output logic      [DATA_W-1:0] prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // Register file side.
    cid_regbus_if.slave            rb
);
    logic              pready_q;   // High through the single access cycle.
    logic              pslverr_q;  // Error answer for an unmapped address.
    logic [DATA_W-1:0] prdata_q;   // Read data caught in the setup cycle.
    logic              setup;      // Setup phase seen this cycle.
    logic              acc;        // Access completes at this edge.

    assign setup    = psel_in & ~penable_in;
    assign acc      = psel_in & penable_in & pready_q;
    // A write lands only at the completing edge, and only where it is mapped.
    assign rb.wr    = acc & pwrite_in & rb.hit;
    assign rb.addr  = paddr_in;
    assign rb.wdata = pwdata_in;

    // Answer is prepared at the setup edge so pready can come from a flop.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end
        else if (setup)
        begin
            pready_q  <= 1'b1;
            pslverr_q <= ~rb.hit;
            prdata_q  <= (rb.hit && !pwrite_in) ? rb.rdata : '0;
        end
        else if (acc)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign prdata_out  = prdata_q;
    assign pready_out  = pready_q;
    assign pslverr_out = pslverr_q;

    // The answer always follows a setup cycle by exactly one edge.
    apb_answer_a : assert property (@(posedge clk_in) disable iff (rst_in)
        (psel_in && !penable_in) |=> pready_q)
        else $error("APB answer did not follow setup.");
endmodule

// file: design/cid_dispatch.sv
// Interrupt dispatch core: pending flags, enables, priority and long call.
//
// What this block does
// - Thirteen sources, two priority levels.
// - Each source owns a readable pending flag.
// - Valid source condition sets its pending flag.
// - Flags set regardless of the enable state.
// - Request raised for a pending, enabled source.
// - Finish instruction, then long call to vector.
// - Return resumes the interrupted instruction flow.
// - Disabled source ignored, program runs on.
// - Every source has its own enable bit.
// - Individual enables need global enable bit seven.
// - Global enable low blocks every source.
// - Flag still set after return: re-enter later.
// - Software setting a flag acts like hardware.
// - High preempts low; high is never preempted.
// - Decode each clock: one detect, four call.
module cid_dispatch import cid_pkg::*; #(
    parameter int                 N_SRC    = NUM_SRC,
    parameter logic [NUM_SRC-1:0] AUTO_CLR = '0
) (
    // Clock and reset.
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // APB register port.
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [DATA_W-1:0] pwdata_in,
    output logic      [DATA_W-1:0] prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // Source condition pulses from peripherals on this clock.
    input  wire logic [N_SRC-1:0]  src_event_in,
    // Instruction sequencer handshake.
    input  wire logic              instr_done_in,
    input  wire logic              return_from_service_in,
    output logic                   long_subroutine_call_start_out,
    output logic                   long_subroutine_call_busy_out,
    output logic      [15:0]       long_subroutine_call_vector_out,
    output logic      [SRC_W-1:0]  long_subroutine_call_src_out,
    // Interrupt line to the system.
    output logic                   irq_out
);
    // The enable layout holds seven plus six sources; refuse anything else.
    if (N_SRC != ENP_SRC_W + ENX_SRC_W)
    begin : g_chk_src
        $error("Source count does not fit the enable layout.");
    end

    cid_regbus_if rb ();

    // Software-visible state.
    logic [N_SRC-1:0] pend_q;     // Pending flags, one per source.
    logic [7:0]       enp_q;      // Primary enable: global bit plus sources 0..6.
    logic [7:0]       enx_q;      // Extended enable: sources 7..12.
    logic [N_SRC-1:0] prio_q;     // One means high priority.
    logic [EV_W-1:0]  stat_q;     // Sticky event status.
    logic [EV_W-1:0]  mask_q;     // Event status interrupt mask.
    // Dispatch state.
    logic             req_q;      // A request was detected last cycle.
    logic [SRC_W-1:0] win_q;      // Source chosen at detection.
    logic             win_hi_q;   // Chosen source is of high priority.
    logic             busy_q;     // Long call in progress.
    logic [2:0]       cnt_q;      // Remaining long call cycles minus one.
    logic             act_hi_q;   // A high-priority routine is in service.
    logic             act_lo_q;   // A low-priority routine is in service.
    logic             skip_q;     // One instruction must run after a return.
    logic             start_q;    // Long call start pulse.
    logic [15:0]      vec_q;      // Vector of the current long call.
    logic [SRC_W-1:0] src_q;      // Source of the current long call.
    logic             irq_q;      // Interrupt output flop.
    // Combinational helpers.
    logic [N_SRC-1:0] src_en;     // Per-source enables gathered from both registers.
    logic [N_SRC-1:0] elig;       // Pending and enabled under the global enable.
    logic             hi_any;     // Some high-priority source is eligible.
    logic             lo_any;     // Some low-priority source is eligible.
    logic [SRC_W-1:0] hi_idx;     // Best high-priority source.
    logic [SRC_W-1:0] lo_idx;     // Best low-priority source.
    logic             cand_hi;    // High source may be taken now.
    logic             cand;       // Some source may be taken now.
    logic             take;       // Dispatch happens at this edge.
    logic [N_SRC-1:0] sw_set;     // Software write-one-to-set of pending flags.
    logic [N_SRC-1:0] sw_clr;     // Software write-one-to-clear of pending flags.
    logic [N_SRC-1:0] hw_clr;     // Auto-clear of the vectored source.
    logic [EV_W-1:0]  ev;         // Events raised this cycle.

    // Register strobes and the bus front end.
    cid_apb_slave u_apb (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .psel_in     (psel_in),
        .penable_in  (penable_in),
        .pwrite_in   (pwrite_in),
        .paddr_in    (paddr_in),
        .pwdata_in   (pwdata_in),
        .prdata_out  (prdata_out),
        .pready_out  (pready_out),
        .pslverr_out (pslverr_out),
        .rb          (rb)
    );

    // Each source has one enable bit, split across the two registers.
    assign src_en = {enx_q[ENX_SRC_W-1:0], enp_q[ENP_SRC_W-1:0]};
    // Global enable gates every individual enable.
    assign elig   = pend_q & src_en & {N_SRC{enp_q[GLOB_BIT]}};

    // Two pickers, one per priority level, each in fixed source order.
    cid_prio_pick #(.N(N_SRC), .W(SRC_W)) u_pick_hi (
        .req_in  (elig & prio_q),
        .any_out (hi_any),
        .idx_out (hi_idx)
    );
    cid_prio_pick #(.N(N_SRC), .W(SRC_W)) u_pick_lo (
        .req_in  (elig & ~prio_q),
        .any_out (lo_any),
        .idx_out (lo_idx)
    );

    // A high routine in service blocks everything; a low one blocks only low.
    assign cand_hi = hi_any && !act_hi_q;
    assign cand    = cand_hi || (lo_any && !act_hi_q && !act_lo_q);

    // Dispatch waits for the end of the current instruction, and after a
    // return one further instruction must complete first.
    assign take = req_q && cand && instr_done_in && !busy_q && !skip_q && !return_from_service_in;

    // Pending flag sources: hardware, software set, software clear, auto-clear.
    assign sw_set = (rb.wr && rb.addr == OFS_PEND) ? rb.wdata[N_SRC-1:0] : '0;
    assign sw_clr = (rb.wr && rb.addr == OFS_PCLR) ? rb.wdata[N_SRC-1:0] : '0;
    assign hw_clr = take ? (AUTO_CLR[N_SRC-1:0] & (N_SRC'(1) << win_q)) : '0;

    // Pending flags: a set in the same cycle as a clear wins, so no event is
    // lost; enables play no part here.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            pend_q <= RST_SRCS[N_SRC-1:0];
        else
            pend_q <= (pend_q & ~(sw_clr | hw_clr)) | src_event_in | sw_set;
    end

    // Enable and priority registers, written only by software.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            enp_q  <= RST_EN;
            enx_q  <= RST_EN;
            prio_q <= RST_SRCS[N_SRC-1:0];
        end
        else if (rb.wr)
        begin
            if (rb.addr == OFS_ENP)
            begin
                enp_q <= rb.wdata[7:0];
            end
            if (rb.addr == OFS_ENX)
            begin
                enx_q <= {2'h0, rb.wdata[ENX_SRC_W-1:0]};
            end
            if (rb.addr == OFS_PRIO)
            begin
                prio_q <= rb.wdata[N_SRC-1:0];
            end
        end
    end

    // Detection stage: sample and decode every clock, one cycle ahead of the call.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            req_q    <= 1'b0;
            win_q    <= '0;
            win_hi_q <= 1'b0;
        end
        else
        begin
            // The level is latched with the source, so a high source that turns
            // up in the dispatch cycle cannot mark the wrong level in service.
            req_q    <= cand;
            win_q    <= cand_hi ? hi_idx : lo_idx;
            win_hi_q <= cand_hi;
        end
    end

    // Long call sequencer: busy for four cycles from the dispatch edge.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            busy_q  <= 1'b0;
            cnt_q   <= 3'h0;
            start_q <= 1'b0;
            vec_q   <= VEC_BASE;
            src_q   <= '0;
        end
        else
        begin
            start_q <= take;
            if (take)
            begin
                busy_q <= 1'b1;
                cnt_q  <= LONG_SUBROUTINE_CALL_CYC - 3'h1;
                src_q  <= win_q;
                vec_q  <= VEC_BASE + (16'(win_q) << VEC_SHIFT);
            end
            else if (busy_q)
            begin
                // The last call cycle releases the sequencer.
                if (cnt_q == 3'h0)
                    busy_q <= 1'b0;
                else
                    cnt_q <= cnt_q - 3'h1;
            end
        end
    end

    // In-service levels: a dispatch marks its level, a return ends the
    // innermost routine, which is the high one whenever both are marked.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            act_hi_q <= 1'b0;
            act_lo_q <= 1'b0;
        end
        else if (take)
        begin
            if (win_hi_q)
                act_hi_q <= 1'b1;
            else
                act_lo_q <= 1'b1;
        end
        else if (return_from_service_in)
        begin
            if (act_hi_q)
                act_hi_q <= 1'b0;
            else
                act_lo_q <= 1'b0;
        end
    end

    // After a return, the resumed flow runs one instruction before any
    // further dispatch; a flag still pending then re-enters at the next instruction end.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            skip_q <= 1'b0;
        else if (return_from_service_in)
            skip_q <= 1'b1;
        else if (instr_done_in)
            skip_q <= 1'b0;
    end

    // Sticky status: dispatch, preemption and return events; set beats clear.
    assign ev[EV_DISP]    = take;
    assign ev[EV_PREEMPT] = take && act_lo_q;
    assign ev[EV_RETURN_FROM_SERVICE]    = return_from_service_in;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            stat_q <= RST_EV;
            mask_q <= RST_EV;
        end
        else
        begin
            if (rb.wr && rb.addr == OFS_STAT)
            begin
                stat_q <= (stat_q & ~rb.wdata[EV_W-1:0]) | ev;
            end
            else
            begin
                stat_q <= stat_q | ev;
            end
            if (rb.wr && rb.addr == OFS_MASK)
            begin
                mask_q <= rb.wdata[EV_W-1:0];
            end
        end
    end

    // The interrupt line follows the masked status one cycle later.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            irq_q <= 1'b0;
        else
            irq_q <= |(stat_q & mask_q);
    end

    // Read decode; unmapped addresses answer with an error from the slave.
    always_comb
    begin
        rb.hit   = 1'b1;
        rb.rdata = '0;
        unique case (rb.addr)
            OFS_PEND, OFS_PCLR: rb.rdata[N_SRC-1:0] = pend_q;
            OFS_ENP:   rb.rdata[7:0]      = enp_q;
            OFS_ENX:   rb.rdata[7:0]      = enx_q;
            OFS_PRIO:  rb.rdata[N_SRC-1:0] = prio_q;
            OFS_STAT:  rb.rdata[EV_W-1:0] = stat_q;
            OFS_MASK:  rb.rdata[EV_W-1:0] = mask_q;
            OFS_STATE:
            begin
                rb.rdata[ST_ACT_LO] = act_lo_q;
                rb.rdata[ST_ACT_HI] = act_hi_q;
                rb.rdata[ST_BUSY]   = busy_q;
                rb.rdata[ST_SKIP]   = skip_q;
                rb.rdata[ST_SRC_LSB +: SRC_W] = src_q;
            end
            default:   rb.hit = 1'b0;
        endcase
    end

    // Outputs straight from flops.
    assign long_subroutine_call_start_out  = start_q;
    assign long_subroutine_call_busy_out   = busy_q;
    assign long_subroutine_call_vector_out = vec_q;
    assign long_subroutine_call_src_out    = src_q;
    assign irq_out          = irq_q;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // A condition pulse leaves its flag set whatever the enables hold.
    flag_set_a : assert property (src_event_in != '0 |=> (pend_q & $past(src_event_in)) == $past(src_event_in))
        else $error("Pending flag missed a source event.");
    // A software set acts like a hardware event.
    sw_set_a : assert property (sw_set != '0 |=> (pend_q & $past(sw_set)) == $past(sw_set))
        else $error("Software set did not reach the pending flag.");
    // No request without the global enable and an enabled pending flag.
    req_gate_a : assert property (req_q |-> $past(enp_q[GLOB_BIT]) && $past(|(pend_q & src_en)))
        else $error("Request raised while blocked.");
    // The call starts only at an instruction end with a detected request.
    call_cause_a : assert property ($rose(busy_q) |-> $past(instr_done_in) && $past(req_q))
        else $error("Long call started without cause.");
    // The long call lasts exactly four cycles.
    call_len_a : assert property (start_q |-> busy_q [*4] ##1 !busy_q)
        else $error("Long call length is wrong.");
    // The vector matches the source.
    vec_map_a : assert property (start_q |-> vec_q == VEC_BASE + (16'(src_q) << VEC_SHIFT))
        else $error("Vector does not match the source.");
    // No dispatch right after a return.
    return_from_service_gap_a : assert property (return_from_service_in |=> !start_q ##1 !start_q)
        else $error("Dispatch without an instruction after return.");
    // A high routine in service is never preempted.
    hi_hold_a : assert property (start_q |-> !$past(act_hi_q, 2))
        else $error("High-priority routine was preempted.");
    // Reset leaves the pending flags and both enable registers cleared.
    rst_clear_a : assert property ($past(rst_in) |-> pend_q == '0 && enp_q == RST_EN && enx_q == RST_EN)
        else $error("Reset did not clear flags and enables.");

    dispatch_c : cover property (start_q);
    preempt_c  : cover property (start_q && act_hi_q && act_lo_q);
    reenter_c  : cover property (return_from_service_in ##[1:20] start_q);
endmodule

// file: tb/cid_seq_model.sv
// Behavioural model of the instruction sequencer beside the dispatcher.
module cid_seq_model (
    // Clock and reset.
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Bench request for one return from service.
    input  wire logic return_from_service_req_in,
    // Sequencer outputs, one-cycle pulses.
    output logic      instr_done_out,
    output logic      return_from_service_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] cnt_q; // Every instruction lasts four cycles, so done follows each wrap of the two-bit count
    // The done pulse is held back in a return cycle, since both may not coincide.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            cnt_q          <= 2'h0;
            instr_done_out <= 1'h0;
            return_from_service_out       <= 1'h0;
        end
        else
        begin
            cnt_q          <= cnt_q + 2'h1;
            instr_done_out <= (cnt_q == 2'h3) && !return_from_service_req_in;
            return_from_service_out       <= return_from_service_req_in;
        end
    end
endmodule

// file: tb/cpu_interrupt_dispatch_bench.sv
// Self-checking bench of the interrupt dispatch block.
module cpu_interrupt_dispatch_bench import cid_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk_in = 1'h0; // System clock, 5 ns period.
    logic              rst    = 1'h1; // Reset, held two cycles.
    logic              psel   = 1'h0;
    logic              pen    = 1'h0;
    logic              pwr    = 1'h0;
    logic [7:0]        padr   = 8'h00;
    logic [31:0]       pwd    = 32'h0;
    logic [31:0]       prd;
    logic              prdy;
    logic              perr;
    logic [NUM_SRC-1:0] sev   = '0; // Source condition pulses.
    logic              rreq   = 1'h0;
    logic              done;
    logic              return_from_service;
    logic              lst;
    logic              lbsy;
    logic [15:0]       lvec;
    logic [3:0]        lsrc;
    logic              irq;
    int                n_mismatch = 0;
    int                cmp_count  = 0;
    always #2.5 clk_in = ~clk_in;
    cid_dispatch uut (.clk_in(clk_in), .rst_in(rst), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
        .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy), .pslverr_out(perr),
        .src_event_in(sev), .instr_done_in(done), .return_from_service_in(return_from_service), .long_subroutine_call_start_out(lst),
        .long_subroutine_call_busy_out(lbsy), .long_subroutine_call_vector_out(lvec), .long_subroutine_call_src_out(lsrc), .irq_out(irq));
    cid_seq_model seq (.clk_in(clk_in), .rst_in(rst), .return_from_service_req_in(rreq), .instr_done_out(done),
        .return_from_service_out(return_from_service));
    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Compares one value, four-state, and counts.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; the request stands until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_in);
        psel <= 1'h1;
        pwr  <= w;
        padr <= a;
        pwd  <= d;
        @(posedge clk_in);
        pen <= 1'h1;
        do @(posedge clk_in); while (prdy !== 1'h1);
        r = prd;
        e = perr;
        psel <= 1'h0;
        pen  <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'h0, a, 32'h0, r, e);
        chk({31'h0, e}, {31'h0, xe});
        chk(r, x);
    endtask
    // One-cycle condition pulse on the given sources.
    task automatic ev(input logic [NUM_SRC-1:0] v);
        @(posedge clk_in);
        sev <= v;
        @(posedge clk_in);
        sev <= '0;
    endtask
    task automatic ret();
        @(posedge clk_in);
        rreq <= 1'h1;
        @(posedge clk_in);
        rreq <= 1'h0;
    endtask
    // Waits a bounded time for a call, then checks vector, source and length.
    task automatic wait_call(input int s);
        int n;
        n = 0;
        #1;
        while (lst !== 1'h1 && n < 60)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        chk({31'h0, lst}, 32'h1);
        chk({16'h0, lvec}, {16'h0, VEC_BASE + (16'(s) << VEC_SHIFT)});
        chk({28'h0, lsrc}, 32'(s));
        n = 0;
        while (lbsy === 1'h1 && n < 20)
        begin
            n++;
            @(posedge clk_in);
            #1;
        end
        chk(32'(n), 32'(LONG_SUBROUTINE_CALL_CYC));
    endtask
    task automatic no_call(input int c);
        repeat (c)
        begin
            @(posedge clk_in);
            #1;
            chk({31'h0, lst}, 32'h0);
        end
    endtask
    // Watchdog: the tests need well under 4000 cycles.
    initial
    begin
        #20000;
        n_mismatch++;
        test_done();
    end
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst <= 1'h0;
        rd_chk(OFS_ENP, 32'h0, 1'h0);
        rd_chk(OFS_ENX, 32'h0, 1'h0);
        rd_chk(OFS_PEND, 32'h0, 1'h0);
        rd_chk(8'h20, 32'h0, 1'h1);
        wr(OFS_MASK, 32'h7);
        wr(OFS_PRIO, 32'h30);
        wr(OFS_ENP, 32'h38);
        ev(13'h0008);
        rd_chk(OFS_PEND, 32'h8, 1'h0);
        no_call(20);
        wr(OFS_ENP, 32'hB8);
        wait_call(3);
        chk({31'h0, irq}, 32'h1);
        ev(13'h0020);
        wait_call(5);
        rd_chk(OFS_STAT, 32'h3, 1'h0);
        rd_chk(OFS_STATE, 32'h53, 1'h0);
        ev(13'h0010);
        no_call(20);
        ret();
        wait_call(4);
        wr(OFS_PCLR, 32'h30);
        ret();
        no_call(20);
        wr(OFS_PCLR, 32'h8);
        ret();
        wr(OFS_ENX, 32'h20);
        wr(OFS_PEND, 32'h1001);
        wait_call(12);
        wr(OFS_PCLR, 32'h1000);
        ret();
        no_call(20);
        rd_chk(OFS_PEND, 32'h1, 1'h0);
        wr(OFS_ENP, 32'h39);
        no_call(12);
        wr(OFS_ENP, 32'hB9);
        wait_call(0);
        wr(OFS_PCLR, 32'h1);
        ret();
        wr(OFS_STAT, 32'h7);
        repeat (3) @(posedge clk_in);
        #1;
        chk({31'h0, irq}, 32'h0);
        test_done();
    end
endmodule
